// ==== bench/tob_cop_model.sv ====
// Coprocessor-side model: free-running clock, wait qualifier and handshakes.
`timescale 1ns/1ps
module tob_cop_model (
  output logic cop_interface_clock,
  output logic cop_clock_qualify_n,
  output logic cop_absent_in,
  output logic cop_busy_in
);
  logic [2:0] cnt_q = 3'h0;
  // The odd offset keeps this clock's edges clear of the sys_clk edges; the 800 ns period fixes its phase to sys_clk.
  initial begin
    {cop_absent_in, cop_clock_qualify_n, cop_busy_in} = 3'h0;
    cop_interface_clock = 1'b0;
    #137;
    forever #400 cop_interface_clock = ~cop_interface_clock;
  end
  // Handshakes move on the falling edge so each holds a full clock period.
  always @(negedge cop_interface_clock) begin
    cnt_q <= cnt_q + 3'h1;
    {cop_absent_in, cop_clock_qualify_n, cop_busy_in} <= cnt_q;
  end
endmodule // tob_cop_model

// ==== bench/tob_trace_port_properties.sv ====
// Checker bound to the trace observation port.
`timescale 1ns/1ps
module tob_trace_port_properties
  import tob_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire tob_core_t   core_in,
  input wire logic        cop_interface_clock,
  input wire logic        cop_clock_qualify_n,
  input wire logic        cop_absent_in,
  input wire logic        cop_busy_in,
  input wire logic [31:0] context_wdata,
  input wire logic        context_we,
  input wire tob_trace_t  trace_out,
  input wire logic        trace_clock_out,
  input wire logic        trace_clock_gate,
  input wire logic        trace_cop_absent,
  input wire logic        trace_cop_busy,
  input wire logic [31:0] trace_context_ident,
  input wire logic        trace_context_ident_wr,
  input wire logic        big_endian_cfg,
  input wire logic        compressed_isa_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_req_follow: assert property (!$past(rst) |->
    trace_out.mem_request_n == !$past(core_in.mem_req_next)) else $error("request");
  chk_write_dir: assert property (!$past(rst) |->
    trace_out.write_not_read == $past(core_in.write)) else $error("direction");
  chk_size_code: assert property (!$past(rst) |-> trace_out.access_size ==
    ($past(core_in.size) == 2'h3 ? TOB_SIZE_WORD : $past(core_in.size))) else $error("size");
  chk_clk_invert: assert property ($rose(cop_interface_clock) |->
    ##[3:4] !trace_clock_out) else $error("trace clock");
  chk_gate_value: assert property ($fell(trace_clock_out) |->
    trace_clock_gate == cop_clock_qualify_n) else $error("gate value");
  chk_gate_hold: assert property ($changed(trace_clock_gate) |->
    $fell(trace_clock_out)) else $error("gate moved");
  chk_busy_copy: assert property ($rose(cop_busy_in) |->
    ##[3:4] trace_cop_busy) else $error("busy");
  chk_absent_copy: assert property ($fell(cop_absent_in) |->
    ##[3:4] !trace_cop_absent) else $error("absent");
  chk_ctx_pulse: assert property (context_we |=>
    trace_context_ident_wr && trace_context_ident == $past(context_wdata)) else $error("ctx");
endmodule // tob_trace_port_properties
bind tob_trace_port tob_trace_port_properties u_chk (.*);

// ==== bench/tob_trace_port_tb.sv ====
// Self-checking bench for the trace observation port.
`timescale 1ns/1ps
module tob_trace_port_tb;
  import tob_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  tob_core_t   core_in = '0;
  logic [31:0] context_wdata = '0;
  logic        context_we = 1'b0;
  logic        cop_clk, cop_qual_n, cop_abs, cop_busy, ctx_wr, big_e, comp;
  logic [31:0] ctx;
  tob_trace_t  trace_out;
  int          err_count = 0;
  int          n_checks = 0;
  always #50 sys_clk = ~sys_clk;
  tob_cop_model u_cop (.cop_interface_clock(cop_clk), .cop_clock_qualify_n(cop_qual_n),
    .cop_absent_in(cop_abs), .cop_busy_in(cop_busy));
  tob_trace_port u_dut (.sys_clk(sys_clk), .rst(rst), .core_in(core_in),
    .cop_interface_clock(cop_clk), .cop_clock_qualify_n(cop_qual_n), .cop_absent_in(cop_abs),
    .cop_busy_in(cop_busy), .context_wdata(context_wdata), .context_we(context_we),
    .trace_out(trace_out), .trace_clock_out(), .trace_clock_gate(), .trace_cop_absent(),
    .trace_cop_busy(), .trace_context_ident(ctx), .trace_context_ident_wr(ctx_wr),
    .big_endian_cfg(big_e), .compressed_isa_state(comp));
  task automatic cmp_tr(tob_trace_t g, tob_trace_t e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t trace %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_w(logic [32:0] g, logic [32:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    tob_core_t   v;
    tob_trace_t  e, exp_q;
    logic [32:0] cfg_q;
    logic [31:0] last_q, addr_q;
    last_q = TOB_ADDR_RST;
    addr_q = 32'h0000_00c0;
    exp_q = TOB_TRACE_RST;
    cfg_q = '0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    // Address steps mix jumps, repeats, +4 and +2 in both instruction states.
    for (int i = 0; i < 17; i++) begin
      v = '0;
      case (i % 4)
        0: addr_q += 32'h0000_0040;
        1: addr_q += TOB_SEQ_STEP_W;
        3: addr_q += TOB_SEQ_STEP_H;
        default: ;
      endcase
      {v.big_endian, v.compressed, v.exec_skip, v.write} = 4'(i);
      {v.mem_req_next, v.next_addr, v.size, v.abort} = {i != 10, addr_q, 2'(i), i == 9};
      {v.opcode_fetch, v.cop_instr, v.debug_state} = {i[1], i[2] ^ i[0], i[3] ^ i[1]};
      v.data = {16'ha5c3, 16'(i)};
      e = '{!v.mem_req_next, v.mem_req_next && (v.next_addr == last_q ||
        v.next_addr == last_q + (v.compressed ? TOB_SEQ_STEP_H : TOB_SEQ_STEP_W)),
        v.exec_skip, !v.cop_instr, v.next_addr, !v.opcode_fetch, v.write,
        (v.size == 2'h3) ? TOB_SIZE_WORD : v.size, v.debug_state, v.data, v.abort};
      if (v.mem_req_next) last_q = v.next_addr;
      @(posedge sys_clk);
      core_in <= v;
      #1;
      if (i > 0) cmp_tr(trace_out, exp_q);
      if (i > 0) cmp_w({31'h0, big_e, comp}, cfg_q);
      exp_q = e;
      cfg_q = {31'h0, v.big_endian, v.compressed};
    end
    // Two back-to-back identifier writes, then two idle cycles.
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      context_we <= (i < 2);
      context_wdata <= 32'hc0de_0000 + 32'(i);
      #1;
      if (i > 0) cmp_w({ctx_wr, ctx}, {i < 3, 32'hc0de_0000 + 32'(i > 1)});
    end
    repeat (400) @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    cmp_tr(trace_out, TOB_TRACE_RST);
    test_done();
  end
endmodule // tob_trace_port_tb

// ==== common/tob_pkg.sv ====
// Package for the trace observation port: widths, reset values and carrier types.
package tob_pkg;

  localparam int          TOB_ADDR_W      = 32;
  localparam int          TOB_DATA_W      = 32;
  localparam logic [1:0]  TOB_SIZE_BYTE   = 2'h0;
  localparam logic [1:0]  TOB_SIZE_HALF   = 2'h1;
  localparam logic [1:0]  TOB_SIZE_WORD   = 2'h2;
  localparam logic [31:0] TOB_ADDR_RST    = 32'h0000_0000;
  localparam logic [31:0] TOB_DATA_RST    = 32'h0000_0000;
  localparam logic [31:0] TOB_CTX_RST     = 32'h0000_0000;
  localparam logic [31:0] TOB_SEQ_STEP_W  = 32'h0000_0004;
  localparam logic [31:0] TOB_SEQ_STEP_H  = 32'h0000_0002;
  localparam int          TOB_SYNC_STAGES = 2;

  // Core-side view of one pipeline cycle, sampled on sys_clk.
  typedef struct packed {
    logic        mem_req_next;
    logic [31:0] next_addr;
    logic        exec_skip;
    logic        cop_instr;
    logic        opcode_fetch;
    logic        write;
    logic [1:0]  size;
    logic        debug_state;
    logic [31:0] data;
    logic        abort;
    logic        big_endian;
    logic        compressed;
  } tob_core_t;

  // Trace bundle as it leaves the block.
  typedef struct packed {
    logic        mem_request_n;
    logic        sequential_addr;
    logic        not_executed;
    logic        cop_instr_n;
    logic [31:0] addr_bus;
    logic        opcode_fetch_n;
    logic        write_not_read;
    logic [1:0]  access_size;
    logic        debug_ack;
    logic [31:0] data_bus;
    logic        access_abort;
  } tob_trace_t;

  localparam tob_trace_t TOB_TRACE_RST = '{
    mem_request_n:   1'b1,
    sequential_addr: 1'b0,
    not_executed:    1'b0,
    cop_instr_n:     1'b1,
    addr_bus:        TOB_ADDR_RST,
    opcode_fetch_n:  1'b1,
    write_not_read:  1'b0,
    access_size:     TOB_SIZE_WORD,
    debug_ack:       1'b0,
    data_bus:        TOB_DATA_RST,
    access_abort:    1'b0
  };

endpackage

// ==== design/tob_trace_port.sv ====
// Trace observation port: retimed processor activity for an external trace unit.
//
// Operation
// - Drive memory request low when an access is needed next cycle.
// - Flag sequential when next address equals last, or last plus four/two.
// - Raise not-executed while the execute-stage instruction is skipped.
// - Hold coprocessor-instruction low while one executes, awaiting absent/busy.
// - Present retimed 32-bit address bus.
// - Opcode-fetch low on instruction fetch, high on data transfer.
// - Write-not-read high for writes, low for reads.
// - Trace clock is the inverse of the coprocessor clock.
// - Clock gate latches the wait qualifier, changing as the high phase starts.
// - Clock gate stays stable through the following low phase.
// - Access size 00 byte, 01 half, 10 word; never 11.
// - Debug acknowledge high in debug state, low in normal state.
// - Present retimed 32-bit data bus.
// - Raise abort when an access was disallowed.
// - Output buffered coprocessor absent.
// - Output buffered coprocessor busy.
// - Drive context identifier; pulse write strobe when it is written.
// - Endianness output high for big-endian, low for little-endian.
// - Instruction-state output high in compressed set, low in 32-bit set.
`timescale 1ns/1ps

module tob_trace_port
  import tob_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire tob_core_t   core_in,
  input  wire logic        cop_interface_clock,
  input  wire logic        cop_clock_qualify_n,
  input  wire logic        cop_absent_in,
  input  wire logic        cop_busy_in,
  input  wire logic [31:0] context_wdata,
  input  wire logic        context_we,
  output tob_trace_t       trace_out,
  output logic             trace_clock_out,
  output logic             trace_clock_gate,
  output logic             trace_cop_absent,
  output logic             trace_cop_busy,
  output logic [31:0]      trace_context_ident,
  output logic             trace_context_ident_wr,
  output logic             big_endian_cfg,
  output logic             compressed_isa_state
);

  // Positions of the coprocessor-side pins in the synchroniser vector.
  localparam int PIN_CLK  = 0;
  localparam int PIN_QUAL = 1;
  localparam int PIN_ABS  = 2;
  localparam int PIN_BUSY = 3;
  localparam int PIN_N    = 4;

  // ------------------------------------------------------------------------
  // Pin synchronisers.
  // ------------------------------------------------------------------------

  // Every coprocessor pin is asynchronous to sys_clk and passes two
  // flip-flops before any logic looks at it. Only the last stage is read
  // outside the loop, so a metastable first stage never fans out.
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_sync;

  assign pin_raw[PIN_CLK]  = cop_interface_clock;
  assign pin_raw[PIN_QUAL] = cop_clock_qualify_n;
  assign pin_raw[PIN_ABS]  = cop_absent_in;
  assign pin_raw[PIN_BUSY] = cop_busy_in;

  for (genvar g = 0; g < PIN_N; g++) begin : g_pin_sync
    logic [TOB_SYNC_STAGES-1:0] stage_q;
    logic [TOB_SYNC_STAGES-1:0] stage_d;

    always_comb begin
      stage_d = {stage_q[TOB_SYNC_STAGES-2:0], pin_raw[g]};
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        stage_q <= '0;
      end else begin
        stage_q <= stage_d;
      end
    end

    assign pin_sync[g] = stage_q[TOB_SYNC_STAGES-1];
  end

  // ------------------------------------------------------------------------
  // Coprocessor clock edge detector.
  // ------------------------------------------------------------------------

  // The previous value resets low, the same level the synchronised clock
  // holds in reset, so no false rising edge follows the release of reset.
  logic cclk_prev_q;
  logic cclk_prev_d;
  logic cclk_rise;

  always_comb begin
    cclk_prev_d = pin_sync[PIN_CLK];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cclk_prev_q <= 1'b0;
    end else begin
      cclk_prev_q <= cclk_prev_d;
    end
  end

  assign cclk_rise = pin_sync[PIN_CLK] & ~cclk_prev_q;

  // ------------------------------------------------------------------------
  // Trace clock and its gate.
  // ------------------------------------------------------------------------

  // Phase two is the high phase of the coprocessor clock. The gate is
  // reloaded only on its rising edge, so it cannot move during the low
  // phase that follows. Both the clock copy and the gate see the same
  // synchroniser delay, which keeps them aligned with each other; the
  // price is a fixed lag of about three sys_clk periods behind the pin.
  logic tclk_q;
  logic tclk_d;
  logic gate_q;
  logic gate_d;

  always_comb begin
    tclk_d = ~pin_sync[PIN_CLK];
    gate_d = gate_q;
    if (cclk_rise) begin
      gate_d = pin_sync[PIN_QUAL];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tclk_q <= 1'b1;
      gate_q <= 1'b0;
    end else begin
      tclk_q <= tclk_d;
      gate_q <= gate_d;
    end
  end

  // ------------------------------------------------------------------------
  // Memory request and sequential address flag.
  // ------------------------------------------------------------------------

  // The sequential flag compares against the last address for which a
  // request was made; idle cycles leave that address untouched, so a
  // request that resumes after a gap can still be flagged sequential.
  logic        req_n_q;
  logic        req_n_d;
  logic        seq_q;
  logic        seq_d;
  logic [31:0] last_addr_q;
  logic [31:0] last_addr_d;
  logic [31:0] step;

  always_comb begin
    step        = core_in.compressed ? TOB_SEQ_STEP_H : TOB_SEQ_STEP_W;
    req_n_d     = ~core_in.mem_req_next;
    seq_d       = 1'b0;
    last_addr_d = last_addr_q;
    if (core_in.mem_req_next) begin
      // The sum wraps at the top of the address space on purpose.
      seq_d       = (core_in.next_addr == last_addr_q) ||
                    (core_in.next_addr == 32'(last_addr_q + step));
      last_addr_d = core_in.next_addr;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_n_q     <= TOB_TRACE_RST.mem_request_n;
      seq_q       <= TOB_TRACE_RST.sequential_addr;
      last_addr_q <= TOB_ADDR_RST;
    end else begin
      req_n_q     <= req_n_d;
      seq_q       <= seq_d;
      last_addr_q <= last_addr_d;
    end
  end

  // ------------------------------------------------------------------------
  // Cycle qualifiers.
  // ------------------------------------------------------------------------

  logic       nexec_q;
  logic       nexec_d;
  logic       cpi_n_q;
  logic       cpi_n_d;
  logic       opc_n_q;
  logic       opc_n_d;
  logic       wnr_q;
  logic       wnr_d;
  logic [1:0] size_q;
  logic [1:0] size_d;
  logic       dbg_q;
  logic       dbg_d;
  logic       abort_q;
  logic       abort_d;

  always_comb begin
    nexec_d = core_in.exec_skip;
    cpi_n_d = ~core_in.cop_instr;
    opc_n_d = ~core_in.opcode_fetch;
    wnr_d   = core_in.write;
    // The reserved code is folded onto word so it never reaches the pins.
    // A trace unit therefore cannot tell a stray reserved code from a word.
    if (core_in.size == 2'h3) begin
      size_d = TOB_SIZE_WORD;
    end else begin
      size_d = core_in.size;
    end
    dbg_d   = core_in.debug_state;
    abort_d = core_in.abort;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      nexec_q <= TOB_TRACE_RST.not_executed;
      cpi_n_q <= TOB_TRACE_RST.cop_instr_n;
      opc_n_q <= TOB_TRACE_RST.opcode_fetch_n;
      wnr_q   <= TOB_TRACE_RST.write_not_read;
      size_q  <= TOB_TRACE_RST.access_size;
      dbg_q   <= TOB_TRACE_RST.debug_ack;
      abort_q <= TOB_TRACE_RST.access_abort;
    end else begin
      nexec_q <= nexec_d;
      cpi_n_q <= cpi_n_d;
      opc_n_q <= opc_n_d;
      wnr_q   <= wnr_d;
      size_q  <= size_d;
      dbg_q   <= dbg_d;
      abort_q <= abort_d;
    end
  end

  // ------------------------------------------------------------------------
  // Address and data buses.
  // ------------------------------------------------------------------------

  // One register stage on each bus; this is the only retiming the trace
  // path adds, so a trace unit sees every cycle exactly one clock late.
  logic [31:0] addr_q;
  logic [31:0] addr_d;
  logic [31:0] data_q;
  logic [31:0] data_d;

  always_comb begin
    addr_d = core_in.next_addr;
    data_d = core_in.data;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_q <= TOB_TRACE_RST.addr_bus;
      data_q <= TOB_TRACE_RST.data_bus;
    end else begin
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  // ------------------------------------------------------------------------
  // Coprocessor handshake copies.
  // ------------------------------------------------------------------------

  // The absent copy resets high, but the synchroniser stages reset low, so
  // it drops one clock after reset, before any handshake has crossed.
  logic abs_q;
  logic abs_d;
  logic busy_q;
  logic busy_d;

  always_comb begin
    abs_d  = pin_sync[PIN_ABS];
    busy_d = pin_sync[PIN_BUSY];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      abs_q  <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      abs_q  <= abs_d;
      busy_q <= busy_d;
    end
  end

  // ------------------------------------------------------------------------
  // Process context identifier.
  // ------------------------------------------------------------------------

  // The identifier and its strobe move together, so a trace unit that
  // samples the bus on the strobe always sees the new value.
  logic [31:0] ctx_q;
  logic [31:0] ctx_d;
  logic        ctx_wr_q;
  logic        ctx_wr_d;

  always_comb begin
    ctx_d    = ctx_q;
    ctx_wr_d = context_we;
    if (context_we) begin
      ctx_d = context_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctx_q    <= TOB_CTX_RST;
      ctx_wr_q <= 1'b0;
    end else begin
      ctx_q    <= ctx_d;
      ctx_wr_q <= ctx_wr_d;
    end
  end

  // ------------------------------------------------------------------------
  // Configuration levels.
  // ------------------------------------------------------------------------

  logic bige_q;
  logic bige_d;
  logic comp_q;
  logic comp_d;

  always_comb begin
    bige_d = core_in.big_endian;
    comp_d = core_in.compressed;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bige_q <= 1'b0;
      comp_q <= 1'b0;
    end else begin
      bige_q <= bige_d;
      comp_q <= comp_d;
    end
  end

  // ------------------------------------------------------------------------
  // Output taps.
  // ------------------------------------------------------------------------

  // Outputs are taps on flip-flops only. Nothing here is read back by the
  // core, so attaching or leaving off a trace unit cannot change execution.
  assign trace_out.mem_request_n   = req_n_q;
  assign trace_out.sequential_addr = seq_q;
  assign trace_out.not_executed    = nexec_q;
  assign trace_out.cop_instr_n     = cpi_n_q;
  assign trace_out.addr_bus        = addr_q;
  assign trace_out.opcode_fetch_n  = opc_n_q;
  assign trace_out.write_not_read  = wnr_q;
  assign trace_out.access_size     = size_q;
  assign trace_out.debug_ack       = dbg_q;
  assign trace_out.data_bus        = data_q;
  assign trace_out.access_abort    = abort_q;

  assign trace_clock_out        = tclk_q;
  assign trace_clock_gate       = gate_q;
  assign trace_cop_absent       = abs_q;
  assign trace_cop_busy         = busy_q;
  assign trace_context_ident    = ctx_q;
  assign trace_context_ident_wr = ctx_wr_q;
  assign big_endian_cfg         = bige_q;
  assign compressed_isa_state   = comp_q;

endmodule // tob_trace_port
